// ==== rtl/brs_framer.sv ====
// binary record framer with output fifo and per-connection status
//
// Operation
// - measured 16-bit, computed 32-bit two's complement
// - format id 1, then block count, block bytes
// - flag byte meaningful only in fifo output
// - flag bit 2 marks decimal/unit change
// - flag bit 1 marks interval change
// - flag bit 0 marks fifo dropout
// - reserved fields and bits 3-6 meaningless
// - summer time 1, winter time 0
// - type byte 00h measured, 80h computed
// - channel numbers start 01 and 31
// - two alarm nibbles per byte, odd low
// - alarm nibble codes 0 through 8
// - overrange and skip sentinel codes
// - burnout, error, undefined sentinel codes
// - counts and data follow selected byte order
// - status is condition AND filter
// - host writes filter, applied to later reports
// - groups 1 and 2 clear after report
// - groups 3 and 4 follow live condition
// - separate filter and held status per connection
`timescale 1ns/10ps
`default_nettype none
`include "brs_map.svh"

// ----------------------------------------------------------------
// byte fifo with registered output stage
// ----------------------------------------------------------------
module brs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clock_in,
   input  wire logic             sys_rst_in,
   input  wire logic             in_valid_in,
   output wire logic             in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output var  logic             out_valid_out,
   input  wire logic             out_ready_in,
   output var  logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [AW:0]      cnt;
   wire          push     = in_valid_in && in_ready_out;
   wire          load     = (cnt != '0) && (!out_valid_out || out_ready_in);
   wire [AW:0]   next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
   // full is counted against storage only; output stage adds one slot
   assign in_ready_out = (cnt != (AW+1)'(DEPTH));
   always_ff @(posedge clock_in) begin
      if (push) begin
         mem[wptr] <= in_data_in;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wptr <= '0;
         rptr <= '0;
         cnt  <= '0;
      end else begin
         wptr <= push ? wptr + 1'b1 : wptr;
         rptr <= load ? rptr + 1'b1 : rptr;
         cnt  <= next_cnt;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         out_valid_out <= 1'b0;
         out_data_out  <= '0;
      end else begin
         out_valid_out <= load || (out_valid_out && !out_ready_in);
         out_data_out  <= load ? mem[rptr] : out_data_out;
      end
   end
endmodule

// ----------------------------------------------------------------
// framer top
// ----------------------------------------------------------------
module brs_framer (
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        start_in,
   input  wire logic        fifo_mode_in,
   input  wire logic        big_endian_in,
   input  wire logic [15:0] block_count_in,
   input  wire logic        sample_valid_in,
   output var  logic        sample_ready_out,
   input  wire logic [31:0] raw_in,
   input  wire logic        is_comp_in,
   input  wire logic [7:0]  chan_idx_in,
   input  wire logic [2:0]  cond_in,
   input  wire logic [3:0]  alarm_level_one_in,
   input  wire logic [3:0]  alarm_level_two_in,
   input  wire logic [3:0]  alarm_level_three_in,
   input  wire logic [3:0]  alarm_level_four_in,
   input  wire logic [6:0]  year_in,
   input  wire logic [3:0]  month_in,
   input  wire logic [4:0]  day_in,
   input  wire logic [4:0]  hour_in,
   input  wire logic [5:0]  minute_in,
   input  wire logic [5:0]  second_in,
   input  wire logic [9:0]  msec_in,
   input  wire logic        summer_time_field_in,
   input  wire logic        unit_changed_in,
   input  wire logic        interval_changed_in,
   input  wire logic        dropout_in,
   output var  logic        byte_valid_out,
   input  wire logic        byte_ready_in,
   output var  logic [7:0]  byte_out,
   output var  logic        busy_out,
   input  wire logic [15:0] event12_in,
   input  wire logic [15:0] level34_in,
   input  wire logic        filter_wr_in,
   input  wire logic        status_rd_in,
   input  wire logic [0:0]  conn_in,
   input  wire logic [31:0] filter_in,
   output var  logic        status_valid_out,
   output var  logic [31:0] status_out
);
   brs_pkg::brs_state_t state;
   brs_pkg::brs_state_t next_state;
   logic [4:0]  idx;
   logic [15:0] blocks;
   logic [15:0] left;
   logic        big;
   logic        mode_fifo;
   logic [7:0]  s_byte [12];
   logic [15:0] s_ms;
   logic [31:0] s_data;
   logic        s_comp;

   // ----------------------------------------------------------------
   // sample encoding
   // ----------------------------------------------------------------
   wire brs_pkg::brs_cond_t cnd = brs_pkg::brs_cond_t'(cond_in);
   wire [15:0] meas_code =
      (cnd == brs_pkg::BRS_POVER)   ? `BRS_M_POVER   :
      (cnd == brs_pkg::BRS_NOVER)   ? `BRS_M_NOVER   :
      (cnd == brs_pkg::BRS_SKIP)    ? `BRS_M_SKIP    :
      (cnd == brs_pkg::BRS_BURN_UP) ? `BRS_M_BURN_UP :
      (cnd == brs_pkg::BRS_BURN_DN) ? `BRS_M_BURN_DN :
      (cnd == brs_pkg::BRS_ERROR)   ? `BRS_M_ERROR   :
      (cnd == brs_pkg::BRS_UNDEF)   ? `BRS_M_UNDEF   :
      raw_in[15:0];
   // computed burnout reuses the overrange codes
   wire [31:0] comp_code =
      (cnd == brs_pkg::BRS_POVER || cnd == brs_pkg::BRS_BURN_UP) ?
         `BRS_C_POVER :
      (cnd == brs_pkg::BRS_NOVER || cnd == brs_pkg::BRS_BURN_DN) ?
         `BRS_C_NOVER :
      (cnd == brs_pkg::BRS_SKIP)  ? `BRS_C_SKIP  :
      (cnd == brs_pkg::BRS_ERROR) ? `BRS_C_ERROR :
      (cnd == brs_pkg::BRS_UNDEF) ? `BRS_C_UNDEF :
      raw_in;
   // bits 3-6 driven zero; latest-data output shows zero flags
   wire [7:0] flag_byte = mode_fifo ?
      {5'h00, unit_changed_in, interval_changed_in, dropout_in} :
      8'h00;
   wire [7:0] chan_type = is_comp_in ? `BRS_TYPE_COMP : `BRS_TYPE_MEAS;
   wire [7:0] chan_num  = chan_idx_in +
      (is_comp_in ? `BRS_COMP_BASE : `BRS_MEAS_BASE);
   // levels out of 0..8 are forced to no alarm
   wire [3:0] a1 = (alarm_level_one_in   > 4'h8) ? 4'h0 : alarm_level_one_in;
   wire [3:0] a2 = (alarm_level_two_in   > 4'h8) ? 4'h0 : alarm_level_two_in;
   wire [3:0] a3 = (alarm_level_three_in > 4'h8) ? 4'h0 : alarm_level_three_in;
   wire [3:0] a4 = (alarm_level_four_in  > 4'h8) ? 4'h0 : alarm_level_four_in;
   wire [7:0] enc [12];
   assign enc[0]  = {1'b0, year_in};
   assign enc[1]  = {4'h0, month_in};
   assign enc[2]  = {3'h0, day_in};
   assign enc[3]  = {3'h0, hour_in};
   assign enc[4]  = {2'h0, minute_in};
   assign enc[5]  = {2'h0, second_in};
   assign enc[6]  = {7'h00, summer_time_field_in};
   assign enc[7]  = flag_byte;
   assign enc[8]  = chan_type;
   assign enc[9]  = chan_num;
   assign enc[10] = {a2, a1};
   assign enc[11] = {a4, a3};

   // ----------------------------------------------------------------
   // byte selection
   // ----------------------------------------------------------------
   function automatic logic [7:0] pick16(input logic [15:0] w,
                                         input logic second,
                                         input logic be);
      pick16 = (be != second) ? w[15:8] : w[7:0];
   endfunction

   wire [7:0] hdr_b [5];
   assign hdr_b[0] = `BRS_FMT_ID;
   assign hdr_b[1] = pick16(blocks, 1'b0, big);
   assign hdr_b[2] = pick16(blocks, 1'b1, big);
   assign hdr_b[3] = pick16(`BRS_BLK_BYTES, 1'b0, big);
   assign hdr_b[4] = pick16(`BRS_BLK_BYTES, 1'b1, big);

   // measured words use two data bytes, the other two are reserved
   wire [15:0] d_first  = (s_comp && big) ? s_data[31:16] : s_data[15:0];
   wire [15:0] d_second = s_comp ? (big ? s_data[15:0] : s_data[31:16]) : 16'h0000;

   wire [7:0] body_b [20];
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_ts
         assign body_b[g] = s_byte[g];
      end
   endgenerate
   assign body_b[6]  = pick16(s_ms, 1'b0, big);
   assign body_b[7]  = pick16(s_ms, 1'b1, big);
   assign body_b[8]  = s_byte[6];
   assign body_b[9]  = s_byte[7];
   assign body_b[10] = 8'h00;
   assign body_b[11] = 8'h00;
   assign body_b[12] = s_byte[8];
   assign body_b[13] = s_byte[9];
   assign body_b[14] = s_byte[10];
   assign body_b[15] = s_byte[11];
   assign body_b[16] = pick16(d_first, 1'b0, big);
   assign body_b[17] = pick16(d_first, 1'b1, big);
   assign body_b[18] = pick16(d_second, 1'b0, big);
   assign body_b[19] = pick16(d_second, 1'b1, big);
   wire       in_hdr    = (state == brs_pkg::BRS_HDR);
   wire       in_body   = (state == brs_pkg::BRS_BODY);
   wire       emit      = in_hdr || in_body;
   wire [7:0] emit_byte = in_hdr ? hdr_b[idx[2:0]] : body_b[idx];
   wire       f_ready;
   wire       adv       = emit && f_ready;
   wire       take      = sample_ready_out && sample_valid_in;
   wire       hdr_done  = adv && in_hdr && (idx == `BRS_HDR_LAST);
   wire       body_done = adv && in_body && (idx == `BRS_BLK_LAST);

   // ----------------------------------------------------------------
   // frame sequencing
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         brs_pkg::BRS_IDLE: begin
            if (start_in) begin
               next_state = brs_pkg::BRS_HDR;
            end
         end
         brs_pkg::BRS_HDR: begin
            if (hdr_done) begin
               next_state = (blocks == 16'h0000) ? brs_pkg::BRS_IDLE : brs_pkg::BRS_WAIT;
            end
         end
         brs_pkg::BRS_WAIT: begin
            if (take) begin
               next_state = brs_pkg::BRS_BODY;
            end
         end
         brs_pkg::BRS_BODY: begin
            if (body_done) begin
               next_state = (left == 16'h0001) ? brs_pkg::BRS_IDLE : brs_pkg::BRS_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state            <= brs_pkg::BRS_IDLE;
         idx              <= 5'h00;
         sample_ready_out <= 1'b0;
         busy_out         <= 1'b0;
      end else begin
         state            <= next_state;
         idx              <= (hdr_done || body_done) ? 5'h00 : (adv ? idx + 5'h01 : idx);
         sample_ready_out <= (next_state == brs_pkg::BRS_WAIT);
         busy_out         <= (next_state != brs_pkg::BRS_IDLE);
      end
   end

   // byte order and mode are frozen for the whole frame
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         blocks    <= 16'h0000;
         left      <= 16'h0000;
         big       <= 1'b0;
         mode_fifo <= 1'b0;
      end else if (state == brs_pkg::BRS_IDLE && start_in) begin
         blocks    <= block_count_in;
         left      <= block_count_in;
         big       <= big_endian_in;
         mode_fifo <= fifo_mode_in;
      end else if (body_done) begin
         left      <= left - 16'h0001;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_byte <= '{default: 8'h00};
         s_ms   <= 16'h0000;
         s_data <= 32'h00000000;
         s_comp <= 1'b0;
      end else if (take) begin
         s_byte <= enc;
         s_ms   <= {6'h00, msec_in};
         s_data <= is_comp_in ? comp_code : {16'h0000, meas_code};
         s_comp <= is_comp_in;
      end
   end

   brs_fifo #(
      .WIDTH (8),
      .DEPTH (`BRS_FIFO_DEPTH)
   ) u_fifo (
      .clock_in      (clock_in),
      .sys_rst_in    (sys_rst_in),
      .in_valid_in   (emit),
      .in_ready_out  (f_ready),
      .in_data_in    (emit_byte),
      .out_valid_out (byte_valid_out),
      .out_ready_in  (byte_ready_in),
      .out_data_out  (byte_out)
   );

   // ----------------------------------------------------------------
   // status conditions, one set per connection
   // ----------------------------------------------------------------
   wire [31:0] report [`BRS_NCONN];
   generate
      for (g = 0; g < `BRS_NCONN; g++) begin : g_conn
         logic [15:0] held12;
         logic [31:0] filt;
         wire         sel   = (conn_in == 1'(g));
         wire         rd_me = status_rd_in && sel;
         // a new event in the clearing cycle survives
         wire [15:0]  next_held12 = (rd_me ? 16'h0000 : held12) | event12_in;

         assign report[g] = {level34_in, held12} & filt;

         always_ff @(posedge clock_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               held12 <= 16'h0000;
               filt   <= `BRS_FILT_RST;
            end else begin
               held12 <= next_held12;
               filt   <= (filter_wr_in && sel) ? filter_in : filt;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_valid_out <= 1'b0;
         status_out       <= 32'h00000000;
      end else begin
         status_valid_out <= status_rd_in;
         status_out       <= status_rd_in ? report[conn_in] : status_out;
      end
   end
endmodule

`default_nettype wire

// ==== rtl/brs_map.svh ====
// offsets, codes and counts for the binary record framer
`ifndef BRS_MAP_SVH
`define BRS_MAP_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define BRS_FMT_ID     8'h01
`define BRS_HDR_LAST   5'h04
`define BRS_BLK_LAST   5'h13
`define BRS_BLK_BYTES  16'h0014
`define BRS_FIFO_DEPTH 32

// ----------------------------------------------------------------
// channel codes
// ----------------------------------------------------------------
`define BRS_TYPE_MEAS  8'h00
`define BRS_TYPE_COMP  8'h80
`define BRS_MEAS_BASE  8'h01
`define BRS_COMP_BASE  8'h1f

// ----------------------------------------------------------------
// sentinel data values
// ----------------------------------------------------------------
`define BRS_M_POVER    16'h7fff
`define BRS_M_NOVER    16'h8001
`define BRS_M_SKIP     16'h8002
`define BRS_M_BURN_UP  16'h7ffa
`define BRS_M_BURN_DN  16'h8006
`define BRS_M_ERROR    16'h8004
`define BRS_M_UNDEF    16'h8005
`define BRS_C_POVER    32'h7fff7fff
`define BRS_C_NOVER    32'h80018001
`define BRS_C_SKIP     32'h80028002
`define BRS_C_ERROR    32'h80048004
`define BRS_C_UNDEF    32'h80058005

// ----------------------------------------------------------------
// status
// ----------------------------------------------------------------
`define BRS_NCONN      2
`define BRS_FILT_RST   32'hffffffff

`endif

// ==== rtl/brs_pkg.sv ====
// types shared by the binary record framer
package brs_pkg;
   typedef enum logic [1:0] {
      BRS_IDLE = 2'h0,
      BRS_HDR  = 2'h1,
      BRS_WAIT = 2'h3,
      BRS_BODY = 2'h2
   } brs_state_t;

   typedef enum logic [2:0] {
      BRS_NORMAL  = 3'h0,
      BRS_POVER   = 3'h1,
      BRS_NOVER   = 3'h2,
      BRS_SKIP    = 3'h3,
      BRS_BURN_UP = 3'h4,
      BRS_BURN_DN = 3'h5,
      BRS_ERROR   = 3'h6,
      BRS_UNDEF   = 3'h7
   } brs_cond_t;
endpackage

// ==== verification/brs_framer_monitor.sv ====
// concurrent checks on the binary record framer ports
`timescale 1ns/10ps
`default_nettype none
module brs_framer_monitor (
   input wire logic        clock_in,
   input wire logic        sys_rst_in,
   input wire logic        start_in,
   input wire logic        byte_valid_out,
   input wire logic        byte_ready_in,
   input wire logic [7:0]  byte_out,
   input wire logic        busy_out,
   input wire logic [15:0] event12_in,
   input wire logic [15:0] level34_in,
   input wire logic        filter_wr_in,
   input wire logic        status_rd_in,
   input wire logic [0:0]  conn_in,
   input wire logic [31:0] filter_in,
   input wire logic        status_valid_out,
   input wire logic [31:0] status_out
);
   // shadow filters and held events, one set per connection
   logic [31:0]      filt [2];
   logic [15:0]      held [2];
   wire logic [31:0] filt_sel = filt[conn_in];
   wire logic [15:0] rep_ev   = held[conn_in] & filt_sel[15:0];
   wire logic [15:0] rep_lv   = level34_in & filt_sel[31:16];
   wire logic        go       = start_in && !busy_out && !byte_valid_out;
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         filt <= '{default: 32'hffffffff};
         held <= '{default: 16'h0000};
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (filter_wr_in && conn_in == 1'(c)) filt[c] <= filter_in;
            held[c] <= (status_rd_in && conn_in == 1'(c) ? 16'h0000 : held[c]) | event12_in;
         end
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   property p_rd_pulse; status_rd_in |=> status_valid_out; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("status answer missing");
   property p_rd_only; !status_rd_in |=> !status_valid_out; endproperty
   a_rd_only: assert property (p_rd_only) else $error("status answer unasked");
   property p_level_rep; status_rd_in |=> status_out[31:16] == $past(rep_lv); endproperty
   a_level_rep: assert property (p_level_rep) else $error("level groups wrong");
   property p_held_rep; status_rd_in |=> status_out[15:0] == $past(rep_ev); endproperty
   a_held_rep: assert property (p_held_rep) else $error("event groups wrong");
   property p_out_hold; !status_rd_in |=> $stable(status_out); endproperty
   a_out_hold: assert property (p_out_hold) else $error("status changed unread");
   property p_go_busy; go |=> busy_out; endproperty
   a_go_busy: assert property (p_go_busy) else $error("frame not started");
   // state edge, push edge, then the output-stage load edge, before the byte is seen
   property p_go_fmt; go |-> ##3 byte_valid_out && byte_out == 8'h01; endproperty
   a_go_fmt: assert property (p_go_fmt) else $error("format byte wrong");
   property p_byte_hold; byte_valid_out && !byte_ready_in |=> byte_valid_out && $stable(byte_out);
   endproperty
   a_byte_hold: assert property (p_byte_hold) else $error("byte dropped in stall");
   c_stall: cover property (byte_valid_out && !byte_ready_in [*8]);
   c_filter: cover property (filter_wr_in ##[1:20] status_rd_in);
   c_frame: cover property (go);
endmodule
`default_nettype wire

// ==== verification/brs_host_sink.sv ====
// host model: byte sink with selectable back-pressure
`timescale 1ns/10ps
`default_nettype none
module brs_host_sink (
   input  wire logic       clock_in,
   input  wire logic       sys_rst_in,
   input  wire logic [1:0] mode_in,
   output var  logic       ready_out
);
   logic [7:0] hold;
   // mode 2 holds off 200 cycles so the fifo fills, then lets go
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hold      <= 8'h00;
         ready_out <= 1'b0;
      end else begin
         hold      <= (mode_in != 2'h2) ? 8'h00 : hold + 8'(hold != 8'hc8);
         ready_out <= mode_in == 2'h0 || (mode_in == 2'h1 && 1'($urandom)) || hold == 8'hc8;
      end
   end
endmodule
`default_nettype wire

// ==== verification/brs_testbench.sv ====
// self-checking bench for the binary record framer
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clock_in, sys_rst_in, start_in, fifo_mode_in, big_endian_in, sample_valid_in;
   logic        is_comp_in, summer_time_field_in, unit_changed_in, interval_changed_in;
   logic        dropout_in, filter_wr_in, status_rd_in, byte_ready_in;
   logic        sample_ready_out, byte_valid_out, busy_out, status_valid_out;
   logic [0:0]  conn_in;
   logic [1:0]  sink_mode;
   logic [2:0]  cond_in;
   logic [3:0]  alarm_level_one_in, alarm_level_two_in;
   logic [3:0]  alarm_level_three_in, alarm_level_four_in, month_in;
   logic [4:0]  day_in, hour_in;
   logic [5:0]  minute_in, second_in;
   logic [6:0]  year_in;
   logic [7:0]  chan_idx_in, byte_out;
   logic [9:0]  msec_in;
   logic [15:0] block_count_in, event12_in, level34_in;
   logic [31:0] raw_in, filter_in, status_out, seed_val;
   logic [7:0]  exp_q [$];
   logic [7:0]  got_q [$];
   int          num_errors, comparisons, cycles;

   brs_framer dut (.*);
   brs_host_sink host (.clock_in, .sys_rst_in, .mode_in(sink_mode), .ready_out(byte_ready_in));

   always #5 clock_in = ~clock_in;

   always @(posedge clock_in) begin
      if (byte_valid_out === 1'b1 && byte_ready_in === 1'b1) got_q.push_back(byte_out);
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic cmp(logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("errors %0d of %0d checks", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   function automatic logic [3:0] alv(logic [3:0] a);
      return (a > 4'h8) ? 4'h0 : a;
   endfunction

   function automatic logic [31:0] data_code(logic comp, logic [2:0] c, logic [31:0] r);
      logic [31:0] m [8];
      logic [31:0] k [8];
      m = '{{16'h0, r[15:0]}, 32'h7fff, 32'h8001, 32'h8002, 32'h7ffa, 32'h8006, 32'h8004, 32'h8005};
      k = '{r, 32'h7fff7fff, 32'h80018001, 32'h80028002, 32'h7fff7fff, 32'h80018001,
            32'h80048004, 32'h80058005};
      return comp ? k[c] : m[c];
   endfunction

   // expected bytes follow the byte order latched for the frame
   task automatic put(logic [31:0] v, int n);
      for (int i = 0; i < n; i++) exp_q.push_back(big_endian_in ? v[8*(n-1-i) +: 8] : v[8*i +: 8]);
   endtask

   task automatic send_block(logic [2:0] c);
      logic [31:0] ts [7];
      logic [31:0] d;
      int n;
      @(posedge clock_in);
      sample_valid_in <= 1'b1;
      cond_in <= c;
      raw_in <= $urandom;
      {is_comp_in, summer_time_field_in} <= 2'($urandom);
      {unit_changed_in, interval_changed_in, dropout_in} <= 3'($urandom);
      chan_idx_in <= 8'($urandom % 12);
      // alarm codes above 8 are sent on purpose
      {alarm_level_one_in, alarm_level_two_in} <= 8'($urandom);
      {alarm_level_three_in, alarm_level_four_in} <= 8'($urandom);
      year_in <= 7'($urandom % 100);
      month_in <= 4'($urandom % 12 + 1);
      day_in <= 5'($urandom % 31 + 1);
      hour_in <= 5'($urandom % 24);
      minute_in <= 6'($urandom % 60);
      second_in <= 6'($urandom % 60);
      msec_in <= 10'($urandom % 1000);
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (sample_ready_out !== 1'b1 && n < 600);
      sample_valid_in <= 1'b0;
      ts = '{32'(year_in), 32'(month_in), 32'(day_in), 32'(hour_in), 32'(minute_in),
             32'(second_in), 32'(msec_in)};
      foreach (ts[i]) put(ts[i], i == 6 ? 2 : 1);
      put(32'(summer_time_field_in), 1);
      d = {29'h0, unit_changed_in, interval_changed_in, dropout_in};
      put(fifo_mode_in ? d : 32'h0, 1);
      put(32'h0, 2);
      put(is_comp_in ? 32'h80 : 32'h00, 1);
      put(32'((is_comp_in ? 8'h1f : 8'h01) + chan_idx_in), 1);
      put({24'h0, alv(alarm_level_two_in), alv(alarm_level_one_in)}, 1);
      put({24'h0, alv(alarm_level_four_in), alv(alarm_level_three_in)}, 1);
      d = data_code(is_comp_in, cond_in, raw_in);
      // raw integer only; point placement is left to the host
      put(d, is_comp_in ? 4 : 2);
      if (!is_comp_in) put(32'h0, 2);
   endtask

   task automatic run_frame(int nb, logic fm, logic be, logic [1:0] sm);
      int n;
      exp_q.delete();
      got_q.delete();
      @(posedge clock_in);
      {start_in, fifo_mode_in, big_endian_in, sink_mode} <= {1'b1, fm, be, sm};
      block_count_in <= 16'(nb);
      @(posedge clock_in);
      start_in <= 1'b0;
      put(32'h01, 1);
      put(32'(nb), 2);
      put(32'h14, 2);
      for (int b = 0; b < nb; b++) send_block(3'(b));
      n = 0;
      while ((busy_out !== 1'b0 || got_q.size() < exp_q.size()) && n < 3000) begin
         @(posedge clock_in);
         n++;
      end
      cmp(got_q.size(), exp_q.size());
      cmp(32'(sample_ready_out), 32'h0);
      foreach (exp_q[i]) cmp(got_q[i], exp_q[i]);
   endtask

   task automatic stat_op(logic [15:0] e, logic wr, logic rd, logic c, logic [31:0] f,
                          logic [31:0] x);
      @(posedge clock_in);
      {event12_in, filter_wr_in, status_rd_in, conn_in, filter_in} <= {e, wr, rd, c, f};
      @(posedge clock_in);
      {event12_in, filter_wr_in, status_rd_in} <= '0;
      #1;
      cmp(status_valid_out, 32'(rd));
      if (rd) cmp(status_out, x);
   endtask

   initial begin
      logic [15:0] ev, lv;
      logic [31:0] f;
      {start_in, fifo_mode_in, big_endian_in, sample_valid_in, is_comp_in, summer_time_field_in,
       unit_changed_in, interval_changed_in, dropout_in, filter_wr_in, status_rd_in} = '0;
      {conn_in, cond_in, alarm_level_one_in, alarm_level_two_in, alarm_level_three_in} = '0;
      {alarm_level_four_in, month_in, day_in, hour_in, minute_in, second_in, year_in} = '0;
      {chan_idx_in, msec_in, block_count_in, event12_in, level34_in, raw_in, filter_in} = '0;
      sink_mode = 2'h0;
      clock_in = 1'b0;
      sys_rst_in = 1'b1;
      seed_val = $urandom(32'had79);
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      run_frame(8, 1'b1, 1'b1, 2'h0);
      run_frame(8, 1'b0, 1'b0, 2'h1);
      run_frame(0, 1'b1, 1'b0, 2'h0);
      run_frame(3, 1'b1, 1'b1, 2'h2);
      repeat (3) run_frame(1 + $urandom % 4, 1'($urandom), 1'($urandom), 2'h1);
      ev = 16'($urandom) | 16'h0101;
      lv = 16'($urandom);
      f = $urandom;
      @(posedge clock_in);
      level34_in <= lv;
      stat_op(ev, 0, 0, 0, 0, 0);
      stat_op(0, 0, 1, 0, 0, {lv, ev});
      stat_op(0, 0, 1, 0, 0, {lv, 16'h0000});
      stat_op(0, 0, 1, 1, 0, {lv, ev});
      stat_op(ev, 1, 0, 0, f, 0);
      stat_op(0, 0, 1, 0, 0, {lv, ev} & f);
      // events reach both connections; only connection 0 was cleared since
      stat_op(0, 0, 1, 1, 0, {lv, ev});
      @(posedge clock_in);
      level34_in <= ~lv;
      stat_op(0, 0, 1, 1, 0, {~lv, 16'h0000});
      close_out();
   end
endmodule

bind brs_framer brs_framer_monitor u_mon (.*);
`default_nettype wire
